// ==== verilog/pofp_params.svh ====
// constants for the start/stop, fault-clear and phase-select command block
`ifndef POFP_PARAMS_SVH
`define POFP_PARAMS_SVH
`define POFP_CMD_START_STOP 8'h02
`define POFP_CMD_FAULT_CLEAR 8'h03
`define POFP_CMD_PHASE_SELECT 8'h04
`define POFP_PHASE_ALL 8'hFF
`define POFP_PHASE_RESET 8'hFF
`define POFP_SS_RESET 5'h00
`define POFP_SS_RSVD_MASK 8'hE0
`define POFP_SS_PU 4
`define POFP_SS_CMD 3
`define POFP_SS_CP 2
`define POFP_SS_POL 1
`define POFP_SS_DLY 0
`define POFP_CLK_NS 5
`define POFP_TICK_NS 1000
`define POFP_TICK_CYC ((`POFP_TICK_NS + `POFP_CLK_NS - 1) / `POFP_CLK_NS)
`endif

// ==== verilog/pofp_pkg.sv ====
// types for the start/stop, fault-clear and phase-select block
`default_nettype none
package pofp_pkg;
	typedef enum logic [1:0] {
		CONV_OFF,
		CONV_RUN,
		CONV_WAIT,
		CONV_RAMP
	} pofp_conv_t;
endpackage
`default_nettype wire

// ==== verilog/pofp_regs.sv ====
// start/stop config, fault clear and phase select with conversion control
`include "pofp_params.svh"
`default_nettype none
module pofp_regs
	import pofp_pkg::*;
#(
	parameter int NFAULT = 4
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// command port from the bus engine
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic cmd_has_data,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_data,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic cmd_invalid,
	// alert handling
	input wire logic ara_answered,
	output logic alert_oe,
	output logic [NFAULT:0] status_bits,
	// power control
	input wire logic enable_lockout_pin,
	input wire logic input_power_good,
	input wire logic [NFAULT-1:0] fault_src,
	input wire logic fault_latchoff,
	input wire logic operation_on_bit,
	input wire logic [15:0] turnoff_wait_time,
	input wire logic [15:0] turnoff_ramp_time,
	output logic convert_en,
	output logic ramp_down,
	output logic pin_uvlo_active,
	// straps and stored defaults
	input wire logic [4:0] nvm_start_stop,
	input wire logic ground_sense_strap,
	input wire logic [1:0] stack_position_cmd,
	input wire logic [2:0] stack_phases,
	output logic [7:0] phase_select,
	output logic [1:0] own_phase,
	output logic phase_addressed
);
	localparam int NS = NFAULT + 2;
	localparam logic [7:0] TICK_LAST = 8'(`POFP_TICK_CYC - 1);

	if (NFAULT < 1 || NFAULT > 16) begin : g_bad_nfault
		$error("NFAULT must be 1 to 16");
	end

	function automatic logic ss_ok(input logic [7:0] d);
		// power-up on pin/command with neither source selected could never start
		return ((d & `POFP_SS_RSVD_MASK) == 8'h00) &&
			(!d[`POFP_SS_PU] || d[`POFP_SS_CMD] || d[`POFP_SS_CP]);
	endfunction

	function automatic logic phase_ok(input logic [7:0] d, input logic [2:0] n);
		return (d == `POFP_PHASE_ALL) || (d < {5'h00, n});
	endfunction

	// pin synchronisers: a change counts once stages two and three agree
	logic [NS-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
	for (genvar i = 0; i < NS; i++) begin : g_filt
		always_comb begin
			filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
		end
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			filt_reg <= '0;
		end else begin
			s1_reg <= {fault_src, input_power_good, enable_lockout_pin};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= filt_next;
		end
	end
	logic pin_lvl, pgood;
	logic [NFAULT-1:0] faults;
	assign pin_lvl = filt_reg[0];
	assign pgood = filt_reg[1];
	assign faults = filt_reg[NS-1:2];

	// one microsecond tick for turn-off timing
	logic [7:0] tick_cnt_reg, tick_cnt_next;
	logic tick;
	assign tick = (tick_cnt_reg == TICK_LAST);
	always_comb begin
		tick_cnt_next = tick ? 8'h00 : tick_cnt_reg + 8'h01;
	end

	// configuration and command decode
	logic loaded_reg, loaded_next;
	logic [4:0] ss_reg, ss_next;
	logic [7:0] phase_reg, phase_next;
	logic [1:0] own_reg, own_next;
	logic [2:0] stack_reg, stack_next;
	logic rsp_v_reg, rsp_v_next;
	logic [7:0] rsp_d_reg, rsp_d_next;
	logic inv_reg, inv_now, clr_now;
	logic addressed;

	assign addressed = (phase_reg == `POFP_PHASE_ALL) || (phase_reg == {6'h00, own_reg});

	always_comb begin
		ss_next = ss_reg;
		phase_next = phase_reg;
		own_next = own_reg;
		stack_next = stack_reg;
		loaded_next = 1'b1;
		rsp_v_next = 1'b0;
		rsp_d_next = rsp_d_reg;
		inv_now = 1'b0;
		clr_now = 1'b0;
		if (!loaded_reg) begin
			// stored defaults and straps are caught one cycle after reset release
			ss_next = nvm_start_stop;
			own_next = ground_sense_strap ? stack_position_cmd : 2'h0;
			stack_next = stack_phases;
		end else if (cmd_valid) begin
			case (cmd_code)
				`POFP_CMD_START_STOP: begin
					if (!cmd_write) begin
						rsp_v_next = 1'b1;
						rsp_d_next = {3'h0, ss_reg};
					end else if (cmd_has_data && ss_ok(cmd_data)) begin
						ss_next = cmd_data[4:0];
					end else begin
						inv_now = 1'b1;
					end
				end
				`POFP_CMD_FAULT_CLEAR: begin
					if (cmd_write && !cmd_has_data) begin
						clr_now = addressed;
					end else begin
						inv_now = 1'b1;
					end
				end
				`POFP_CMD_PHASE_SELECT: begin
					if (!cmd_write) begin
						rsp_v_next = 1'b1;
						rsp_d_next = phase_reg;
					end else if (cmd_has_data && phase_ok(cmd_data, stack_reg)) begin
						phase_next = cmd_data;
					end else begin
						inv_now = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// start/stop decision
	logic pu, cmdb, cp, pol, dly;
	logic pin_on, pin_term, cmd_term, want, pin_off, run_ok;
	assign pu = ss_reg[`POFP_SS_PU];
	assign cmdb = ss_reg[`POFP_SS_CMD];
	assign cp = ss_reg[`POFP_SS_CP];
	assign pol = ss_reg[`POFP_SS_POL];
	assign dly = ss_reg[`POFP_SS_DLY];
	assign pin_on = pol ? pin_lvl : !pin_lvl;
	assign pin_term = !cp || pin_on;
	assign cmd_term = !cmdb || operation_on_bit;
	assign want = loaded_reg && pgood &&
		(!pu || (pin_term && cmd_term && (cp || cmdb)));
	assign pin_off = pu && cp && !pin_on && cmd_term;

	// latch-off is released only when want drops (off request or power-good loss), never by a fault clear
	logic latch_reg, latch_next, want_d_reg, toggle_clr;
	assign latch_next = fault_latchoff || (latch_reg && want);
	assign run_ok = want && !latch_reg;
	assign toggle_clr = want && !want_d_reg;

	// sticky status and alert; a set in the clearing cycle wins
	logic [NFAULT:0] status_reg, status_next, set_in;
	logic alert_reg, alert_next, raise, wipe;
	assign set_in = {inv_now, faults};
	assign wipe = clr_now || toggle_clr;
	// sticky bits keep a source blocked until wiped, so only new sources alert
	assign raise = |(set_in & (~status_reg | {(NFAULT + 1){wipe}}));
	always_comb begin
		status_next = (wipe ? '0 : status_reg) | set_in;
		alert_next = (alert_reg && !ara_answered && !wipe) || raise;
	end

	// conversion sequencer
	pofp_conv_t state_reg, state_next;
	logic [15:0] cnt_reg, cnt_next;
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			CONV_OFF: begin
				if (run_ok) begin
					state_next = CONV_RUN;
				end
			end
			CONV_RUN: begin
				if (!run_ok) begin
					if (pin_off && !dly && pgood && !latch_reg) begin
						state_next = CONV_WAIT;
						cnt_next = turnoff_wait_time;
					end else begin
						state_next = CONV_OFF;
					end
				end
			end
			CONV_WAIT: begin
				if (run_ok) begin
					state_next = CONV_RUN;
				end else if (latch_reg || !pgood) begin
					state_next = CONV_OFF;
				end else if (tick) begin
					if (cnt_reg == 16'h0000) begin
						state_next = CONV_RAMP;
						cnt_next = turnoff_ramp_time;
					end else begin
						cnt_next = cnt_reg - 16'h0001;
					end
				end
			end
			CONV_RAMP: begin
				if (run_ok) begin
					state_next = CONV_RUN;
				end else if (latch_reg || !pgood) begin
					state_next = CONV_OFF;
				end else if (tick) begin
					if (cnt_reg == 16'h0000) begin
						state_next = CONV_OFF;
					end else begin
						cnt_next = cnt_reg - 16'h0001;
					end
				end
			end
			default: begin
				state_next = CONV_OFF;
			end
		endcase
	end

	logic conv_reg, ramp_reg, uvlo_reg, addr_reg;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tick_cnt_reg <= 8'h00;
			loaded_reg <= 1'b0;
			ss_reg <= `POFP_SS_RESET;
			phase_reg <= `POFP_PHASE_RESET;
			own_reg <= 2'h0;
			stack_reg <= 3'h0;
			rsp_v_reg <= 1'b0;
			rsp_d_reg <= 8'h00;
			inv_reg <= 1'b0;
			latch_reg <= 1'b0;
			want_d_reg <= 1'b0;
			status_reg <= '0;
			alert_reg <= 1'b0;
			state_reg <= CONV_OFF;
			cnt_reg <= 16'h0000;
			conv_reg <= 1'b0;
			ramp_reg <= 1'b0;
			uvlo_reg <= 1'b0;
			addr_reg <= 1'b0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			loaded_reg <= loaded_next;
			ss_reg <= ss_next;
			phase_reg <= phase_next;
			own_reg <= own_next;
			stack_reg <= stack_next;
			rsp_v_reg <= rsp_v_next;
			rsp_d_reg <= rsp_d_next;
			inv_reg <= inv_now;
			latch_reg <= latch_next;
			want_d_reg <= want;
			status_reg <= status_next;
			alert_reg <= alert_next;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			conv_reg <= (state_next != CONV_OFF);
			ramp_reg <= (state_next == CONV_RAMP);
			uvlo_reg <= cp && pol;
			addr_reg <= addressed;
		end
	end

	assign rsp_valid = rsp_v_reg;
	assign rsp_data = rsp_d_reg;
	assign cmd_invalid = inv_reg;
	assign alert_oe = alert_reg;
	assign status_bits = status_reg;
	assign convert_en = conv_reg;
	assign ramp_down = ramp_reg;
	assign pin_uvlo_active = uvlo_reg;
	assign phase_select = phase_reg;
	assign own_phase = own_reg;
	assign phase_addressed = addr_reg;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	sequence pin_drop_s;
		loaded_reg && state_reg == CONV_RUN && pin_off && pgood && !latch_reg && !run_ok;
	endsequence

	rsvd_read_a: assert property (loaded_reg && cmd_valid && !cmd_write &&
		cmd_code == `POFP_CMD_START_STOP |=> rsp_valid && rsp_data[7:5] == 3'h0)
		else $error("start/stop readback upper bits not zero");
	powerup_run_a: assert property (state_reg == CONV_OFF && loaded_reg && !pu &&
		pgood && !latch_reg |=> convert_en)
		else $error("conversion not started with power-up bit clear");
	cmd_off_a: assert property (state_reg == CONV_RUN && loaded_reg && pu && cmdb &&
		!operation_on_bit |=> !convert_en)
		else $error("command off not obeyed");
	uvlo_gate_a: assert property (pin_uvlo_active |->
		$past(ss_reg[`POFP_SS_CP]) && $past(ss_reg[`POFP_SS_POL]))
		else $error("lockout active without high-polarity pin");
	soft_off_a: assert property (pin_drop_s ##0 !dly |=> convert_en && !ramp_down &&
		state_reg == CONV_WAIT)
		else $error("pin off did not hold regulation");
	fast_off_a: assert property (pin_drop_s ##0 dly |=> !convert_en)
		else $error("pin off not immediate");
	ss_reject_a: assert property (loaded_reg && cmd_valid && cmd_write &&
		cmd_code == `POFP_CMD_START_STOP && cmd_data[7:5] != 3'h0 |=>
		cmd_invalid && status_bits[NFAULT] &&
		(alert_oe || $past(status_bits[NFAULT])) && ss_reg == $past(ss_reg))
		else $error("bad start/stop value accepted");
	clr_alert_a: assert property (clr_now && !(|faults) |=> !alert_oe &&
		status_bits == '0)
		else $error("fault clear left alert or status");
	latch_keep_a: assert property (latch_reg && want && clr_now |=> latch_reg)
		else $error("fault clear released latch-off");
	refault_a: assert property (clr_now && faults[0] |=> status_bits[0] && alert_oe)
		else $error("persisting fault not re-flagged");
	ara_keep_a: assert property (ara_answered && !raise && !wipe |=>
		!alert_oe && status_bits == $past(status_bits))
		else $error("alert response changed status or kept alert");
	phase_reset_a: assert property (loaded_reg && !$past(loaded_reg) |->
		phase_select == `POFP_PHASE_RESET)
		else $error("phase select not at reset value");
	phase_reject_a: assert property (loaded_reg && cmd_valid && cmd_write &&
		cmd_code == `POFP_CMD_PHASE_SELECT && !phase_ok(cmd_data, stack_reg) |=>
		cmd_invalid && phase_select == $past(phase_select))
		else $error("unsupported phase accepted");
endmodule
`default_nettype wire

// ==== testbench/pofp_host_model.sv ====
// host model issuing byte commands on the command port
`default_nettype none
module pofp_host_model (
	// clock
	input wire logic clk_sys,
	// command port
	output logic cmd_valid,
	output logic cmd_write,
	output logic cmd_has_data,
	output logic [7:0] cmd_code,
	output logic [7:0] cmd_data,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic cmd_invalid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic got_rsp, got_inv;
	logic [7:0] got_data;
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_has_data = 1'b0;
		cmd_code = 8'h00;
		cmd_data = 8'h00;
	end
	// one request, held to its taking edge; answer read just after that edge
	task automatic xfer(input logic wr, input logic hd, input logic [7:0] code,
			input logic [7:0] data);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_has_data <= hd;
		cmd_code <= code;
		cmd_data <= data;
		@(posedge clk_sys);
		// idle lines carry the inverse, so a stale copy is never mistaken for data
		cmd_valid <= 1'b0;
		cmd_write <= ~wr;
		cmd_has_data <= ~hd;
		cmd_code <= ~code;
		cmd_data <= ~data;
		#1;
		got_rsp = rsp_valid;
		got_inv = cmd_invalid;
		got_data = rsp_data;
	endtask
	task automatic wr_byte(input logic [7:0] code, input logic [7:0] data);
		xfer(1'b1, 1'b1, code, data);
	endtask
	task automatic send_byte(input logic [7:0] code);
		xfer(1'b1, 1'b0, code, 8'h00);
	endtask
	task automatic rd_byte(input logic [7:0] code);
		xfer(1'b0, 1'b0, code, 8'h00);
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the start/stop, fault clear and phase select block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, srst, ara, pin, pgood, latch, op;
	logic cmd_valid, cmd_write, cmd_has_data, rsp_valid, cmd_invalid, alert_oe;
	logic convert_en, ramp_down, pin_uvlo_active, phase_addressed;
	logic [7:0] cmd_code, cmd_data, rsp_data, phase_select;
	logic [4:0] status_bits;
	logic [3:0] fault_src;
	logic [1:0] own_phase;
	logic gs_strap;
	logic [15:0] wait_t, ramp_t;
	logic [4:0] nvm_ss;
	logic [1:0] stack_pos;
	logic [2:0] stack_n;
	logic [11:0] pwr_tab [11] = '{12'h152, 12'h158, 12'h152, 12'h171, 12'h17B,
		12'h1F9, 12'h1FF, 12'h1F5, 12'h186, 12'h180, 12'h1A6};
	int num_errors = 0;
	int n_checks = 0;
	int i;
	pofp_host_model pofp_host_model_i (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_has_data(cmd_has_data), .cmd_code(cmd_code),
		.cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.cmd_invalid(cmd_invalid));
	pofp_regs #(.NFAULT(4)) pofp_regs_i (.clk_sys(clk_sys), .srst(srst),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_has_data(cmd_has_data),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .cmd_invalid(cmd_invalid), .ara_answered(ara),
		.alert_oe(alert_oe), .status_bits(status_bits), .enable_lockout_pin(pin),
		.input_power_good(pgood), .fault_src(fault_src), .fault_latchoff(latch),
		.operation_on_bit(op), .turnoff_wait_time(wait_t),
		.turnoff_ramp_time(ramp_t), .convert_en(convert_en), .ramp_down(ramp_down),
		.pin_uvlo_active(pin_uvlo_active), .nvm_start_stop(nvm_ss),
		.ground_sense_strap(gs_strap), .stack_position_cmd(stack_pos),
		.stack_phases(stack_n),
		.phase_select(phase_select), .own_phase(own_phase),
		.phase_addressed(phase_addressed));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chkb(input logic seen, input logic exp);
		chk({7'h00, seen}, {7'h00, exp});
	endtask
	task automatic chks(input logic [4:0] exp);
		chk({3'h0, status_bits}, {3'h0, exp});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic pins(input logic p, input logic o);
		@(posedge clk_sys);
		pin <= p;
		op <= o;
	endtask
	task automatic results;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// generous bound: the whole sequence needs under two thousand cycles
	initial begin
		#100000;
		num_errors++;
		results();
	end
	initial begin
		srst = 1'b1;
		ara = 1'b0;
		pin = 1'b0;
		pgood = 1'b1;
		latch = 1'b0;
		op = 1'b0;
		fault_src = 4'h0;
		wait_t = 16'h0001;
		ramp_t = 16'h0002;
		nvm_ss = 5'h00;
		gs_strap = 1'b0;
		stack_pos = 2'h1;
		stack_n = 3'h4;
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		cyc(8);
		chk(phase_select, 8'hFF);
		pofp_host_model_i.rd_byte(8'h04);
		chk(pofp_host_model_i.got_data, 8'hFF);
		chkb(pofp_host_model_i.got_rsp, 1'b1);
		pofp_host_model_i.rd_byte(8'h02);
		chk(pofp_host_model_i.got_data, 8'h00);
		chkb(convert_en, 1'b1);
		pofp_host_model_i.wr_byte(8'h02, 8'h34);
		chkb(pofp_host_model_i.got_inv, 1'b1);
		pofp_host_model_i.wr_byte(8'h02, 8'h10);
		chkb(pofp_host_model_i.got_inv, 1'b1);
		pofp_host_model_i.send_byte(8'h02);
		chkb(pofp_host_model_i.got_inv, 1'b1);
		pofp_host_model_i.rd_byte(8'h02);
		chk(pofp_host_model_i.got_data, 8'h00);
		chks(5'h10);
		chkb(alert_oe, 1'b1);
		pins(1'b0, 1'b0);
		ara <= 1'b1;
		@(posedge clk_sys);
		ara <= 1'b0;
		cyc(2);
		chkb(alert_oe, 1'b0);
		chks(5'h10);
		pofp_host_model_i.wr_byte(8'h02, 8'hE0);
		chkb(pofp_host_model_i.got_inv, 1'b1);
		cyc(2);
		chkb(alert_oe, 1'b0);
		pofp_host_model_i.send_byte(8'h03);
		chks(5'h00);
		chkb(alert_oe, 1'b0);
		pofp_host_model_i.rd_byte(8'h03);
		chkb(pofp_host_model_i.got_inv, 1'b1);
		chkb(pofp_host_model_i.got_rsp, 1'b0);
		pofp_host_model_i.wr_byte(8'h04, 8'h05);
		chkb(pofp_host_model_i.got_inv, 1'b1);
		chk(phase_select, 8'hFF);
		for (i = 3; i >= 0; i--) begin
			pofp_host_model_i.wr_byte(8'h04, 8'(i ^ 3));
			pofp_host_model_i.rd_byte(8'h04);
			chk(pofp_host_model_i.got_data, 8'(i ^ 3));
		end
		cyc(2);
		chk({6'h00, own_phase}, 8'h00);
		chkb(phase_addressed, 1'b0);
		pofp_host_model_i.send_byte(8'h03);
		chks(5'h10);
		pofp_host_model_i.wr_byte(8'h04, 8'h00);
		cyc(2);
		chkb(phase_addressed, 1'b1);
		pofp_host_model_i.send_byte(8'h03);
		chks(5'h00);
		pofp_host_model_i.wr_byte(8'h04, 8'hFF);
		@(posedge clk_sys);
		fault_src <= 4'h1;
		cyc(10);
		chks(5'h01);
		chkb(alert_oe, 1'b1);
		pofp_host_model_i.send_byte(8'h03);
		chks(5'h01);
		chkb(alert_oe, 1'b1);
		@(posedge clk_sys);
		fault_src <= 4'h0;
		cyc(10);
		pofp_host_model_i.send_byte(8'h03);
		chks(5'h00);
		foreach (pwr_tab[k]) begin
			pofp_host_model_i.wr_byte(8'h02, pwr_tab[k][11:4]);
			pins(pwr_tab[k][3], pwr_tab[k][2]);
			cyc(12);
			chkb(convert_en, pwr_tab[k][1]);
			chkb(pin_uvlo_active, pwr_tab[k][0]);
		end
		pofp_host_model_i.wr_byte(8'h02, 8'h16);
		pins(1'b1, 1'b0);
		cyc(12);
		chkb(convert_en, 1'b1);
		pins(1'b0, 1'b0);
		cyc(20);
		chkb(convert_en, 1'b1);
		chkb(ramp_down, 1'b0);
		for (i = 0; i < 1000 && ramp_down !== 1'b1; i++) cyc(1);
		chkb(ramp_down, 1'b1);
		for (i = 0; i < 1000 && convert_en !== 1'b0; i++) cyc(1);
		chkb(convert_en, 1'b0);
		// the ramp lasts one tick of 200 cycles more than its programmed count
		chkb(i == (ramp_t + 1) * 200, 1'b1);
		pofp_host_model_i.wr_byte(8'h02, 8'h00);
		cyc(12);
		chkb(convert_en, 1'b1);
		@(posedge clk_sys);
		latch <= 1'b1;
		@(posedge clk_sys);
		latch <= 1'b0;
		cyc(4);
		pofp_host_model_i.send_byte(8'h03);
		cyc(12);
		chkb(convert_en, 1'b0);
		@(posedge clk_sys);
		pgood <= 1'b0;
		cyc(12);
		chkb(convert_en, 1'b0);
		@(posedge clk_sys);
		pgood <= 1'b1;
		cyc(12);
		chkb(convert_en, 1'b1);
		// second reset as a follower in a three-phase stack
		@(posedge clk_sys);
		srst <= 1'b1;
		gs_strap <= 1'b1;
		stack_pos <= 2'h2;
		stack_n <= 3'h3;
		nvm_ss <= 5'h1B;
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		cyc(8);
		chk({6'h00, own_phase}, 8'h02);
		chk(phase_select, 8'hFF);
		chkb(convert_en, 1'b0);
		pofp_host_model_i.rd_byte(8'h02);
		chk(pofp_host_model_i.got_data, 8'h1B);
		@(posedge clk_sys);
		op <= 1'b1;
		cyc(4);
		chkb(convert_en, 1'b1);
		pofp_host_model_i.wr_byte(8'h04, 8'h03);
		chkb(pofp_host_model_i.got_inv, 1'b1);
		pofp_host_model_i.wr_byte(8'h04, 8'h02);
		chkb(pofp_host_model_i.got_inv, 1'b0);
		cyc(2);
		chkb(phase_addressed, 1'b1);
		results();
	end
endmodule
`default_nettype wire
